// [src/link_status_pkg.sv]
// Constants and types for the port link status and rate fallback block
package link_status_pkg;
  localparam int unsigned CLK_FREQ_HZ = 250_000_000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam longint unsigned BLINK_HALF_CYC_L = longint'(CLK_FREQ_HZ) * BLINK_HALF_MS / 1000;
  localparam int unsigned BLINK_HALF_CYC = int'(BLINK_HALF_CYC_L);
  localparam int unsigned NUM_PORTS = 9;
  // Divider count at which the speed-cap strap is caught after reset release
  localparam int unsigned CAP_SAMPLE_CNT = 2;
  localparam logic [1:0] RATE_GEN1 = 2'h1;
  localparam logic [1:0] RATE_GEN2 = 2'h2;

  // Per-port view of the training state machine
  typedef struct packed {
    logic link_up;      // Link is in L0 or beyond
    logic rate_gen2;    // Current rate is 5 GT/s
    logic detect_exit;  // One-cycle pulse when leaving Detect
    logic cfg_fail;     // One-cycle pulse when Configuration fails
  } ltssm_ev_t;

  // Advertisement carried in outgoing training sets
  typedef struct packed {
    logic gen2_rate;    // Gen2 data rate advertised
    logic auto_change;  // Autonomous speed change supported
  } ts_adv_t;
endpackage

// [src/port_adv_ctrl.sv]
// Per-port status output and training set advertisement logic
`timescale 1ns/10ps
module port_adv_ctrl (
  input wire logic clk_sys,                       // Core clock
  input wire logic rst_n,                         // Synchronised reset, active low
  input wire link_status_pkg::ltssm_ev_t ev,      // Training state machine view
  input wire logic blink_phase,                   // Shared half-second phase
  input wire logic fallback_en,                   // Fallback enabled (strap low)
  input wire logic speed_cap_gen2,                // Latched speed cap, high allows Gen2
  output logic status_n,                          // Registered active-low status
  output link_status_pkg::ts_adv_t adv            // Registered advertisement
);
  import link_status_pkg::*;

  logic fallback_reg;
  logic fallback_next;
  logic pending_reg;
  logic pending_next;
  logic status_next;
  ts_adv_t adv_next;

  assign status_next = !ev.link_up ? 1'b1 : (ev.rate_gen2 ? 1'b0 : blink_phase);

  // failure arms a toggle that takes effect at Detect exit
  assign pending_next = !fallback_en ? 1'b0 : (ev.cfg_fail ? 1'b1 : (ev.detect_exit ? 1'b0 : pending_reg));
  assign fallback_next = !fallback_en ? 1'b0 :
                         ((ev.detect_exit && pending_reg) ? !fallback_reg : fallback_reg);

  assign adv_next.gen2_rate = speed_cap_gen2 && !fallback_next;
  assign adv_next.auto_change = speed_cap_gen2 && !fallback_next;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_n <= 1'b1;
      fallback_reg <= 1'b0;
      pending_reg <= 1'b0;
      adv <= '0;
    end else begin
      status_n <= status_next;
      fallback_reg <= fallback_next;
      pending_reg <= pending_next;
      adv <= adv_next;
    end
  end

  a_down_high: assert property (@(posedge clk_sys) disable iff (!rst_n) !ev.link_up |=> status_n)
    else $error("status low while link down");
  a_gen2_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev.link_up && ev.rate_gen2 |=> !status_n)
    else $error("status high at 5 GT/s");
  a_gen1_blink: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev.link_up && !ev.rate_gen2 |=> status_n == $past(blink_phase))
    else $error("status does not blink at 2.5 GT/s");
  a_strap_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fallback_en && speed_cap_gen2 |=> adv.gen2_rate && adv.auto_change)
    else $error("Gen2 not advertised with strap high");
  // detect exit after failure flips advertisement
  a_fail_flip: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fallback_en && pending_reg && ev.detect_exit ##1 fallback_en && speed_cap_gen2
    |-> adv.gen2_rate != $past(adv.gen2_rate))
    else $error("advertisement did not alternate");
  a_fail_arm: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fallback_en && ev.cfg_fail && !ev.detect_exit |=> pending_reg)
    else $error("failure not remembered");
  a_cap_gen1: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !speed_cap_gen2 |=> !adv.gen2_rate && !adv.auto_change)
    else $error("Gen2 advertised while capped");
endmodule // port_adv_ctrl

// [src/port_link_status.sv]
// Top of the port link status and rate fallback block
`timescale 1ns/10ps
module port_link_status #(
  parameter int unsigned PORTS = link_status_pkg::NUM_PORTS,            // Number of ports
  parameter int unsigned HALF_CYC = link_status_pkg::BLINK_HALF_CYC     // Cycles per blink phase
) (
  input wire logic clk_sys,                                            // Core clock, 250 MHz
  input wire logic resetn,                                             // Fundamental reset, active low
  input wire logic fallback_strap_n,                                   // Fallback strap, low enables fallback
  input wire logic speed_cap_strap_n,                                  // Speed cap strap, high allows 5 GT/s
  input wire link_status_pkg::ltssm_ev_t ltssm [PORTS],                // Per-port training view
  output logic port_link_ok_n [PORTS],                                 // Per-port status, active low
  output link_status_pkg::ts_adv_t training_set_adv [PORTS]            // Per-port advertisement
);
  import link_status_pkg::*;

  localparam int CW = $clog2(HALF_CYC);
  localparam logic [CW-1:0] CAP_AT = CW'(CAP_SAMPLE_CNT);
  localparam logic [CW-1:0] DIV_LAST = CW'(HALF_CYC - 1);

  logic rst_s1_reg;
  logic rst_s2_reg;
  logic fb_s1_reg;
  logic fb_s2_reg;
  logic cap_s1_reg;
  logic cap_s2_reg;
  logic cap_gen2_reg;
  logic cap_taken_reg;
  logic [CW-1:0] div_reg;
  logic [CW-1:0] div_next;
  logic blink_reg;
  logic div_wrap;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // Strap synchronisers
  always_ff @(posedge clk_sys or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      fb_s1_reg <= 1'b1;
      fb_s2_reg <= 1'b1;
      cap_s1_reg <= 1'b1;
      cap_s2_reg <= 1'b1;
    end else begin
      fb_s1_reg <= fallback_strap_n;
      fb_s2_reg <= fb_s1_reg;
      cap_s1_reg <= speed_cap_strap_n;
      cap_s2_reg <= cap_s1_reg;
    end
  end

  // speed cap caught once after release, once synchronised
  always_ff @(posedge clk_sys or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      cap_gen2_reg <= 1'b1;
      cap_taken_reg <= 1'b0;
    end else if (!cap_taken_reg && div_reg == CAP_AT) begin
      cap_gen2_reg <= cap_s2_reg;
      cap_taken_reg <= 1'b1;
    end
  end

  assign div_wrap = (div_reg == DIV_LAST);
  assign div_next = div_wrap ? '0 : div_reg + CW'(1);

  always_ff @(posedge clk_sys or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      div_reg <= '0;
      blink_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      blink_reg <= div_wrap ? !blink_reg : blink_reg;
    end
  end

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    port_adv_ctrl u_ctrl (
      .clk_sys(clk_sys),
      .rst_n(rst_s2_reg),
      .ev(ltssm[p]),
      .blink_phase(blink_reg),
      .fallback_en(!fb_s2_reg),
      .speed_cap_gen2(cap_gen2_reg),
      .status_n(port_link_ok_n[p]),
      .adv(training_set_adv[p])
    );
  end

  // blink phase holds for exactly the half period
  a_blink_hold: assert property (@(posedge clk_sys) disable iff (!rst_s2_reg)
    $changed(blink_reg) |-> div_reg == '0)
    else $error("blink toggled off the divider wrap");

  // divider never passes its last count
  a_div_range: assert property (@(posedge clk_sys) disable iff (!rst_s2_reg)
    div_reg <= DIV_LAST)
    else $error("divider beyond its last count");

  // wrap always flips the blink phase
  a_wrap_flip: assert property (@(posedge clk_sys) disable iff (!rst_s2_reg)
    div_wrap |=> blink_reg != $past(blink_reg))
    else $error("blink phase missed the wrap");

  // speed cap is caught once and then held
  a_cap_hold: assert property (@(posedge clk_sys) disable iff (!rst_s2_reg)
    cap_taken_reg |=> cap_taken_reg && $stable(cap_gen2_reg))
    else $error("speed cap changed after capture");

  // capture happens at the sample count
  a_cap_take: assert property (@(posedge clk_sys) disable iff (!rst_s2_reg)
    !cap_taken_reg && div_reg == CAP_AT |=> cap_taken_reg && cap_gen2_reg == $past(cap_s2_reg))
    else $error("speed cap not captured");

  a_rst_sync: assert property (@(posedge clk_sys) disable iff (!resetn)
    rst_s2_reg |-> rst_s1_reg)
    else $error("internal reset released out of order");
endmodule // port_link_status

// [testbench/link_partner_model.sv]
// Training state machine stand-in that raises one port's events
`timescale 1ns/10ps
module link_partner_model #(
  parameter int unsigned PORTS = 9 // Number of ports
) (
  input wire logic clk_sys, // Core clock
  input wire logic train, // Start one training attempt
  input wire logic refuse, // Attempt fails in Configuration
  input wire logic [3:0] port, // Port being trained
  input wire logic [PORTS-1:0] up, // Link up per port
  input wire logic [PORTS-1:0] gen2, // Running at 5 GT/s per port
  output link_status_pkg::ltssm_ev_t ltssm [PORTS] // Events toward the block
);
  logic [2:0] step_reg = 3'h0;
  // Attempt sequencer: Detect exit first, failure two cycles later
  always_ff @(posedge clk_sys) begin
    step_reg <= train ? 3'h1 : ((step_reg != 3'h0) ? step_reg + 3'h1 : 3'h0);
  end
  // Events land only on the port under training
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      ltssm[p].link_up = up[p];
      ltssm[p].rate_gen2 = gen2[p];
      ltssm[p].detect_exit = (p == port) && (step_reg == 3'h1);
      ltssm[p].cfg_fail = (p == port) && refuse && (step_reg == 3'h3);
    end
  end
endmodule // link_partner_model

// [testbench/port_link_status_tb.sv]
// Self-checking bench for the port link status block
`timescale 1ns/10ps
module port_link_status_tb;
  import link_status_pkg::*;
  localparam int unsigned HC = 8;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic fb_n = 1'b1;
  logic cap_n = 1'b1;
  logic train = 1'b0;
  logic refuse = 1'b0;
  logic [3:0] port = 4'h0;
  logic [NUM_PORTS-1:0] up = '0;
  logic [NUM_PORTS-1:0] gen2 = '0;
  ltssm_ev_t ev [NUM_PORTS];
  logic ok_n [NUM_PORTS];
  ts_adv_t adv [NUM_PORTS];
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  port_link_status #(.PORTS(NUM_PORTS), .HALF_CYC(HC)) u_port_link_status (.clk_sys(clk_sys), .resetn(resetn),
    .fallback_strap_n(fb_n), .speed_cap_strap_n(cap_n), .ltssm(ev), .port_link_ok_n(ok_n), .training_set_adv(adv));
  link_partner_model #(.PORTS(NUM_PORTS)) u_link_partner_model (.clk_sys(clk_sys), .train(train), .refuse(refuse),
    .port(port), .up(up), .gen2(gen2), .ltssm(ev));
  // Clock and hang guard
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One training attempt, then let the advertisement settle
  task automatic attempt(input logic fail);
    refuse <= fail;
    train <= 1'b1;
    @(posedge clk_sys);
    train <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_status();
    int toggles;
    logic prev;
    up <= 9'h006;
    gen2 <= 9'h002;
    repeat (3) @(posedge clk_sys);
    #1;
    prev = ok_n[2];
    toggles = 0;
    for (int i = 0; i < 4 * HC; i++) begin
      chk("down port", 4'h1, {3'h0, ok_n[0]});
      chk("gen2 port", 4'h0, {3'h0, ok_n[1]});
      @(posedge clk_sys);
      #1;
      toggles += int'(ok_n[2] !== prev);
      prev = ok_n[2];
    end
    chk("blink toggles", 4'h4, 4'(toggles));
  endtask
  task automatic t_fallback();
    port <= 4'h3;
    attempt(1'b1);
    chk("strap high adv", 4'h3, {2'h0, adv[3]});
    attempt(1'b1);
    chk("strap high adv", 4'h3, {2'h0, adv[3]});
    fb_n <= 1'b0;
    attempt(1'b1);
    chk("first fail adv", 4'h3, {2'h0, adv[3]});
    attempt(1'b1);
    chk("gen1 only adv", 4'h0, {2'h0, adv[3]});
    attempt(1'b0);
    chk("alternate adv", 4'h3, {2'h0, adv[3]});
    attempt(1'b0);
    chk("no fail keeps adv", 4'h3, {2'h0, adv[3]});
    // Board pulls the strap high again
    fb_n <= 1'b1;
  endtask
  task automatic t_reset();
    resetn <= 1'b0;
    cap_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("reset status", 4'h1, {3'h0, ok_n[1]});
    chk("reset adv", 4'h0, {2'h0, adv[0]});
    resetn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    port <= 4'h0;
    attempt(1'b0);
    chk("capped adv", 4'h0, {2'h0, adv[0]});
    chk("status after reset", 4'h0, {3'h0, ok_n[1]});
  endtask
  task automatic summarize();
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    t_status();
    t_fallback();
    t_reset();
    summarize();
  end
endmodule // port_link_status_tb
